// >>> osdgr_defines.svh
// Address map, field positions and fixed constants of the glyph fetch block
`ifndef OSDGR_DEFINES_SVH
`define OSDGR_DEFINES_SVH

// ==========================================================
// Register byte offsets
`define OSDGR_CTRL_OFS 12'h000
`define OSDGR_STAT_OFS 12'h004
`define OSDGR_CAPT_OFS 12'h008
`define OSDGR_WLO_OFS 12'h00C
`define OSDGR_WMID_OFS 12'h010
`define OSDGR_WHI_OFS 12'h014

// ==========================================================
// Control register fields
`define OSDGR_HIRES_BIT 0
`define OSDGR_MULT_LSB 8
`define OSDGR_BANK_BIT 7
`define OSDGR_SIZE20_BIT 12
`define OSDGR_CTRL_RST 32'h0000_0000
`define OSDGR_CTRL_MASK 32'h0000_1381

// ==========================================================
// Status register fields
`define OSDGR_BUSY_BIT 0
`define OSDGR_RANGE_BIT 1
`define OSDGR_REJECT_BIT 2

// ==========================================================
// Glyph store layout, in 16-bit words
`define OSDGR_BANK0_BASE 14'h0000
`define OSDGR_BANK1_BASE 14'h1000
`define OSDGR_EXT0_BASE 14'h1000
`define OSDGR_EXT1_BASE 14'h2000
`define OSDGR_STORE_WORDS 14'd9210
`define OSDGR_MAIN_LINES 5'd16
`define OSDGR_LINES_HIRES 5'd18
`define OSDGR_LINES_BIG 5'd20

`endif

// >>> osdgr_pkg.sv
// Types shared by the glyph fetch block
package osdgr_pkg;
	// Horizontal enlargement factor
	typedef enum logic [1:0] {
		OSDGR_X1,
		OSDGR_X2,
		OSDGR_X3,
		OSDGR_XRSV
	} osdgr_mult_t;
	// Fetch sequencer
	typedef enum logic [1:0] {
		OSDGR_IDLE,
		OSDGR_READ,
		OSDGR_LATCH,
		OSDGR_SPREAD
	} osdgr_state_t;
endpackage

// >>> osdgr_widen.sv
// Bit duplicating widener: one glyph line into three output words
`timescale 1ns/1ps
module osdgr_widen #(
	parameter int WIDTH = 16
) (
	input wire logic [WIDTH-1:0] line_in,
	input wire osdgr_pkg::osdgr_mult_t mult,
	output logic [WIDTH-1:0] word_hi,
	output logic [WIDTH-1:0] word_mid,
	output logic [WIDTH-1:0] word_lo
);
	import osdgr_pkg::*;

	logic [2*WIDTH-1:0] dbl;
	logic [3*WIDTH-1:0] tpl;

	// ==========================================================
	// Duplication
	// Pure wiring, no multiplier; source bit i lands on ranks 2i to 2i+1, or 3i to 3i+2
	// Highest source bit ends up leftmost in the high word
	genvar i;
	generate
		for (i = 0; i < WIDTH; i = i + 1) begin : g_dup
			assign dbl[2*i+1 -: 2] = {2{line_in[i]}};
			assign tpl[3*i+2 -: 3] = {3{line_in[i]}};
		end
	endgenerate

	// ==========================================================
	// Output selection
	// Single size lands in the low word only
	always_comb begin
		word_hi = '0;
		word_mid = '0;
		word_lo = '0;
		case (mult)
			OSDGR_X2: begin
				word_hi = dbl[2*WIDTH-1 -: WIDTH];
				word_mid = dbl[WIDTH-1:0];
			end
			OSDGR_X3: begin
				word_hi = tpl[3*WIDTH-1 -: WIDTH];
				word_mid = tpl[2*WIDTH-1 -: WIDTH];
				word_lo = tpl[WIDTH-1:0];
			end
			default: word_lo = line_in;
		endcase
	end
endmodule

// >>> osdgr_top.sv
// Glyph store addressing, capture and widening with an AHB-Lite register port
//
// The register offsets and the AHB-Lite register port were decided locally.
`timescale 1ns/1ps
`include "osdgr_defines.svh"

module osdgr_top #(
	parameter int ADDR_W = 14,
	parameter int DATA_W = 16
) (
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// Character register side
	input wire logic fetch_valid,
	output logic fetch_ready,
	input wire logic [7:0] fetch_code,
	input wire logic [4:0] fetch_line,
	// Glyph ROM port, one cycle read latency
	output logic glyph_rom_en,
	output logic [ADDR_W-1:0] glyph_rom_addr,
	input wire logic [DATA_W-1:0] glyph_rom_data,
	// Pixel serialiser side
	output logic pix_valid,
	output logic [DATA_W-1:0] pix_hi,
	output logic [DATA_W-1:0] pix_mid,
	output logic [DATA_W-1:0] pix_lo
);
	import osdgr_pkg::*;

	logic [31:0] ctrl_reg;
	logic range_err_reg;
	logic reject_reg;
	osdgr_state_t state_reg;
	logic [ADDR_W-1:0] addr_reg;
	logic addr_ok_reg;
	logic [DATA_W-1:0] capt_reg;
	logic [DATA_W-1:0] wide_hi;
	logic [DATA_W-1:0] wide_mid;
	logic [DATA_W-1:0] wide_lo;
	logic bus_we_reg;
	logic [11:0] bus_addr_reg;
	logic addr_phase;
	logic wr_ctrl;
	logic wr_stat;
	logic bank1;
	logic big;
	logic hires;
	osdgr_mult_t mult;
	logic [4:0] last_line;
	logic line_ok;
	logic take;
	logic [ADDR_W-1:0] main_addr;
	logic [ADDR_W-1:0] ext_addr;
	logic [ADDR_W-1:0] addr_next;
	logic [4:0] line_idx;
	logic [4:0] ext_idx;
	logic [31:0] ctrl_view;
	logic [31:0] stat_view;
	logic [31:0] rd_word;

	// ==========================================================
	// Control decode
	assign bank1 = ctrl_reg[`OSDGR_BANK_BIT];
	assign big = ctrl_reg[`OSDGR_SIZE20_BIT];
	assign hires = ctrl_reg[`OSDGR_HIRES_BIT];
	// Factor code 11 is reserved and widens like single size
	assign mult = osdgr_mult_t'(ctrl_reg[`OSDGR_MULT_LSB +: 2]);

	// Tallest line the current matrix allows
	// Twenty lines win over the high resolution bit when both are set
	always_comb begin
		if (big) begin
			last_line = `OSDGR_LINES_BIG;
		end else if (hires) begin
			last_line = `OSDGR_LINES_HIRES;
		end else begin
			last_line = `OSDGR_MAIN_LINES;
		end
	end

	// ==========================================================
	// AHB-Lite slave
	// Zero wait state, always OKAY; only word transfers are expected
	// Single slave: the system loops hreadyout back as hready
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign addr_phase = hsel & htrans[1] & hready;

	// Capture the address phase for the write data phase
	// Write data arrives a cycle after its address, hence the copy
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			bus_we_reg <= 1'b0;
			bus_addr_reg <= 12'h000;
		end else begin
			bus_we_reg <= addr_phase & hwrite;
			bus_addr_reg <= haddr[11:0];
		end
	end

	assign wr_ctrl = bus_we_reg & (bus_addr_reg == `OSDGR_CTRL_OFS);
	assign wr_stat = bus_we_reg & (bus_addr_reg == `OSDGR_STAT_OFS);

	// Control register; unimplemented bits stay zero
	// Only bank, height, resolution and factor bits are kept
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_reg <= `OSDGR_CTRL_RST;
		end else if (wr_ctrl) begin
			ctrl_reg <= hwdata & `OSDGR_CTRL_MASK;
		end
	end

	// ==========================================================
	// Register read path
	// A pipelined master may read right behind a write, so the read's address
	// phase meets the write's data phase; a control word being written is shown then
	always_comb begin
		ctrl_view = ctrl_reg;
		if (wr_ctrl) begin
			ctrl_view = hwdata & `OSDGR_CTRL_MASK;
		end
	end

	// Status word; busy is live, the two error flags are sticky
	always_comb begin
		stat_view = 32'h0000_0000;
		stat_view[`OSDGR_BUSY_BIT] = state_reg != OSDGR_IDLE;
		stat_view[`OSDGR_RANGE_BIT] = range_err_reg;
		stat_view[`OSDGR_REJECT_BIT] = reject_reg;
	end

	// Word picked by the address phase; unmapped offsets read as zero
	always_comb begin
		case (haddr[11:0])
			`OSDGR_CTRL_OFS: rd_word = ctrl_view;
			`OSDGR_STAT_OFS: rd_word = stat_view;
			`OSDGR_CAPT_OFS: rd_word = {{(32-DATA_W){1'b0}}, capt_reg};
			`OSDGR_WLO_OFS: rd_word = {{(32-DATA_W){1'b0}}, pix_lo};
			`OSDGR_WMID_OFS: rd_word = {{(32-DATA_W){1'b0}}, pix_mid};
			`OSDGR_WHI_OFS: rd_word = {{(32-DATA_W){1'b0}}, pix_hi};
			default: rd_word = 32'h0000_0000;
		endcase
	end

	// Read data is registered in the address phase so it stands in the data phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0000_0000;
		end else if (addr_phase & !hwrite) begin
			hrdata <= rd_word;
		end
	end

	// ==========================================================
	// Address generation
	// Lines are numbered from one; zero and lines past the matrix are refused
	// Limitation: bank zero extras share the bank one area at its base, so with
	// tall bank zero glyphs the first bank one characters are not usable
	assign line_ok = (fetch_line != 5'd0) && (fetch_line <= last_line);
	assign line_idx = fetch_line - 5'd1;
	assign ext_idx = fetch_line - `OSDGR_MAIN_LINES - 5'd1;

	// Main region: base plus code*16 plus line-1
	assign main_addr = (bank1 ? `OSDGR_BANK1_BASE : `OSDGR_BANK0_BASE)
		+ {2'b00, fetch_code, 4'h0} + {10'h000, line_idx[3:0]};

	// Extra lines: two words per character, four in the twenty-line matrix
	always_comb begin
		ext_addr = bank1 ? `OSDGR_EXT1_BASE : `OSDGR_EXT0_BASE;
		if (big) begin
			ext_addr = ext_addr + {4'h0, fetch_code, 2'b00} + {12'h000, ext_idx[1:0]};
		end else begin
			ext_addr = ext_addr + {5'h00, fetch_code, 1'b0} + {13'h0000, ext_idx[0]};
		end
	end

	assign addr_next = (fetch_line > `OSDGR_MAIN_LINES) ? ext_addr : main_addr;

	// ==========================================================
	// Fetch sequencer
	// One line per request; the character register is held off while busy
	// Three busy cycles: strobe the ROM, take its word, widen it
	assign fetch_ready = state_reg == OSDGR_IDLE;
	assign take = fetch_valid & fetch_ready;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_reg <= OSDGR_IDLE;
		end else begin
			case (state_reg)
				OSDGR_IDLE: if (take) state_reg <= OSDGR_READ;
				OSDGR_READ: state_reg <= OSDGR_LATCH;
				OSDGR_LATCH: state_reg <= OSDGR_SPREAD;
				OSDGR_SPREAD: state_reg <= OSDGR_IDLE;
				default: state_reg <= OSDGR_IDLE;
			endcase
		end
	end

	// Request address and its validity; past the store limit nothing is read
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			addr_reg <= '0;
			addr_ok_reg <= 1'b0;
		end else if (take) begin
			addr_reg <= addr_next;
			addr_ok_reg <= line_ok && (addr_next < `OSDGR_STORE_WORDS);
		end
	end

	// ROM strobe only for addresses inside the store
	// The ROM answers one cycle after the strobe, in the latch cycle
	assign glyph_rom_en = (state_reg == OSDGR_READ) & addr_ok_reg;
	assign glyph_rom_addr = addr_ok_reg ? addr_reg : '0;

	// Sticky error flags; a new event beats a write-one clear
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			range_err_reg <= 1'b0;
			reject_reg <= 1'b0;
		end else begin
			if (state_reg == OSDGR_READ && !addr_ok_reg && addr_reg >= `OSDGR_STORE_WORDS) begin
				range_err_reg <= 1'b1;
			end else if (wr_stat && hwdata[`OSDGR_RANGE_BIT]) begin
				range_err_reg <= 1'b0;
			end
			if (take && !line_ok) begin
				reject_reg <= 1'b1;
			end else if (wr_stat && hwdata[`OSDGR_REJECT_BIT]) begin
				reject_reg <= 1'b0;
			end
		end
	end

	// ==========================================================
	// Capture register
	// A refused or out-of-range line shows as an all-dark row
	// Dark rather than stale, so a bad request never repeats an old glyph
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			capt_reg <= '0;
		end else if (state_reg == OSDGR_LATCH) begin
			capt_reg <= addr_ok_reg ? glyph_rom_data : '0;
		end
	end

	// ==========================================================
	// Widening
	osdgr_widen #(
		.WIDTH(DATA_W)
	) u_widen (
		.line_in(capt_reg),
		.mult(mult),
		.word_hi(wide_hi),
		.word_mid(wide_mid),
		.word_lo(wide_lo)
	);

	// Output words are registered; the factor is sampled as the line is spread
	// Trade-off: a factor written during a fetch already applies to that line
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pix_hi <= '0;
			pix_mid <= '0;
			pix_lo <= '0;
			pix_valid <= 1'b0;
		end else begin
			pix_valid <= state_reg == OSDGR_SPREAD;
			if (state_reg == OSDGR_SPREAD) begin
				pix_hi <= wide_hi;
				pix_mid <= wide_mid;
				pix_lo <= wide_lo;
			end
		end
	end
endmodule

// >>> osdgr_monitor.sv
// Port checker for the glyph fetch block
`timescale 1ns/1ps
module osdgr_monitor #(
	parameter int ADDR_W = 14,
	parameter int DATA_W = 16
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic fetch_valid,
	input wire logic fetch_ready,
	input wire logic [7:0] fetch_code,
	input wire logic [4:0] fetch_line,
	input wire logic glyph_rom_en,
	input wire logic [ADDR_W-1:0] glyph_rom_addr,
	input wire logic pix_valid,
	input wire logic [DATA_W-1:0] pix_hi,
	input wire logic [DATA_W-1:0] pix_mid,
	input wire logic [DATA_W-1:0] pix_lo
);
	// ==========================================
	// Helpers
	logic take;
	// Request accepted at this edge
	assign take = fetch_valid && fetch_ready;
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// ==========================================
	// Assertions
	store_limit_a: assert property (glyph_rom_en |-> glyph_rom_addr < 14'h23FA)
		else $error("glyph read beyond store limit");
	fetch_busy_a: assert property (take |=> !fetch_ready [*3] ##1 fetch_ready)
		else $error("fetch ready spacing wrong");
	pix_latency_a: assert property (take |-> ##4 pix_valid)
		else $error("line result not four cycles after take");
	rom_cause_a: assert property (glyph_rom_en |-> $past(take))
		else $error("glyph read without a request");
	main_addr_a: assert property (take && fetch_line inside {[1:16]} |=> glyph_rom_en &&
		glyph_rom_addr[13] == 1'h0 &&
		glyph_rom_addr[11:0] == {$past(fetch_code), $past(fetch_line[3:0]) - 4'h1})
		else $error("main line address wrong");
	rom_pulse_a: assert property (glyph_rom_en |=> !glyph_rom_en [*3])
		else $error("more than one word per line");
	pix_hold_a: assert property (!pix_valid |-> $stable({pix_hi, pix_mid, pix_lo}))
		else $error("pixel words changed between lines");
	dup_pairs_a: assert property (pix_valid |-> pix_hi[15] == pix_hi[14] &&
		pix_mid[15] == pix_mid[14])
		else $error("leading bits not duplicated");
	// Main scenarios reached
	cover property (take && fetch_line > 5'h10);
	cover property (pix_valid && pix_hi != 16'h0000);
	cover property (glyph_rom_en && glyph_rom_addr[13]);
endmodule
bind osdgr_top osdgr_monitor #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) mon (.hclk(hclk),
	.hresetn(hresetn), .fetch_valid(fetch_valid), .fetch_ready(fetch_ready),
	.fetch_code(fetch_code), .fetch_line(fetch_line), .glyph_rom_en(glyph_rom_en),
	.glyph_rom_addr(glyph_rom_addr), .pix_valid(pix_valid), .pix_hi(pix_hi),
	.pix_mid(pix_mid), .pix_lo(pix_lo));

// >>> osdgr_rom_model.sv
// Glyph ROM model with one cycle read latency
`timescale 1ns/1ps
module osdgr_rom_model (
	input wire logic clk,
	input wire logic en,
	input wire logic [13:0] addr,
	output logic [15:0] data
);
	// ==========================================
	// Read port
	initial data = 16'h0000;
	// Toggles when not read so a stale capture shows up
	always @(posedge clk) begin
		if (en) begin
			data <= {2'h2, addr} ^ 16'h3C5A;
		end else begin
			data <= ~data;
		end
	end
endmodule

// >>> tb_top.sv
// Self-checking bench for the glyph fetch block
`timescale 1ns/1ps
module tb_top;
	logic hclk = 1'h0;
	logic hresetn = 1'h0;
	logic hsel = 1'h0;
	logic hwrite = 1'h0;
	logic fetch_valid = 1'h0;
	logic [1:0] htrans = 2'h0;
	logic [31:0] haddr = 32'h0000_0000;
	logic [31:0] hwdata = 32'h0000_0000;
	logic [7:0] fetch_code = 8'h00;
	logic [4:0] fetch_line = 5'h00;
	logic hready, hresp, fetch_ready, rom_en, pix_valid;
	logic [31:0] hrdata, rd;
	logic [13:0] rom_addr;
	logic [15:0] rom_data, pix_hi, pix_mid, pix_lo;
	logic [47:0] exp_q[$];
	logic [31:0] seed = 32'h0DE0_AE9A;
	logic [4:0] lines [8] = '{5'h01, 5'h10, 5'h11, 5'h12, 5'h13, 5'h14, 5'h00, 5'h15};
	int bad_count = 0;
	int num_checks = 0;
	// ==========================================
	// Clock, reset, parts
	initial forever #12.5 hclk = ~hclk;
	initial begin
		repeat (5) @(posedge hclk);
		hresetn <= 1'h1;
	end
	osdgr_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
		.hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .fetch_valid(fetch_valid),
		.fetch_ready(fetch_ready), .fetch_code(fetch_code), .fetch_line(fetch_line),
		.glyph_rom_en(rom_en), .glyph_rom_addr(rom_addr), .glyph_rom_data(rom_data),
		.pix_valid(pix_valid), .pix_hi(pix_hi), .pix_mid(pix_mid), .pix_lo(pix_lo));
	osdgr_rom_model rom (.clk(hclk), .en(rom_en), .addr(rom_addr), .data(rom_data));
	// ==========================================
	// Tasks
	task automatic chk(input logic [47:0] got, input logic [47:0] exp);
		num_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// Single word transfer; waits on hready, never assumes a count
	task automatic ahb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
		logic r;
		hsel <= 1'h1;
		htrans <= 2'h2;
		hwrite <= wr;
		haddr <= {20'h0_0000, a};
		do begin @(negedge hclk); r = hready; @(posedge hclk); end while (r !== 1'h1);
		hsel <= 1'h0;
		htrans <= 2'h0;
		hwdata <= wd;
		do begin @(negedge hclk); r = hready; rd = hrdata; @(posedge hclk); end while (r !== 1'h1);
		chk({47'h0, hresp}, 48'h0);
	endtask
	// Leaves valid up so back-to-back calls never drive it twice in one step
	task automatic fetch(input logic [7:0] c, input logic [4:0] l, input logic [47:0] e);
		logic r;
		fetch_valid <= 1'h1;
		fetch_code <= c;
		fetch_line <= l;
		do begin @(negedge hclk); r = fetch_ready; @(posedge hclk); end while (r !== 1'h1);
		exp_q.push_back(e);
	endtask
	function automatic logic [47:0] line_exp(input logic [12:0] cfg, input logic [7:0] c,
		input logic [4:0] l);
		logic [15:0] a, w;
		logic [31:0] d2;
		logic [47:0] d3;
		logic [4:0] h;
		h = cfg[12] ? 5'h14 : (cfg[0] ? 5'h12 : 5'h10);
		if (l <= 5'h10) a = (cfg[7] ? 16'h1000 : 16'h0000) + c * 16'h0010 + l - 16'h0001;
		else a = (cfg[7] ? 16'h2000 : 16'h1000) + c * (cfg[12] ? 16'h0004 : 16'h0002) + l - 16'h0011;
		w = (l == 5'h00 || l > h || a >= 16'h23FA) ? 16'h0000 : {2'h2, a[13:0]} ^ 16'h3C5A;
		for (int i = 0; i < 16; i++) begin
			d2[2*i+:2] = {2{w[i]}};
			d3[3*i+:3] = {3{w[i]}};
		end
		case (cfg[9:8])
			2'h1: return {d2, 16'h0000};
			2'h2: return d3;
			default: return {32'h0000_0000, w};
		endcase
	endfunction
	task automatic close_out();
		if (bad_count == 0 && num_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	// ==========================================
	// Result watcher: oldest note against each line
	always @(posedge hclk) begin
		if (pix_valid === 1'h1) begin
			chk({pix_hi, pix_mid, pix_lo}, exp_q.size() ? exp_q.pop_front() : 48'hx);
		end
	end
	initial begin
		#500000;
		bad_count++;
		close_out();
	end
	// ==========================================
	// Main sequence: every bank, height and factor
	initial begin
		logic [12:0] cfg;
		logic [7:0] c;
		logic [47:0] e, w;
		repeat (6) @(posedge hclk);
		ahb(1'h0, 12'h000, 32'h0000_0000);
		chk(rd, 48'h0);
		ahb(1'h0, 12'h01C, 32'h0000_0000);
		chk(rd, 48'h0);
		for (int k = 0; k < 32; k++) begin
			cfg = {k[4], 2'h0, k[1:0], k[2], 6'h00, k[3]};
			ahb(1'h1, 12'h000, {19'h0_0000, cfg});
			ahb(1'h0, 12'h000, 32'h0000_0000);
			chk(rd, {35'h0, cfg});
			c = 8'($random(seed));
			foreach (lines[j]) fetch(j[0] ? 8'hFF : c, lines[j], line_exp(cfg, j[0] ? 8'hFF : c, lines[j]));
			fetch_valid <= 1'h0;
			while (exp_q.size() != 0) @(posedge hclk);
		end
		ahb(1'h0, 12'h004, 32'h0000_0000);
		chk(rd[2:1], 48'h3);
		ahb(1'h1, 12'h004, 32'h0000_0006);
		ahb(1'h0, 12'h004, 32'h0000_0000);
		chk(rd[2:1], 48'h0);
		e = line_exp(cfg, 8'h41, 5'h03);
		fetch(8'h41, 5'h03, e);
		fetch_valid <= 1'h0;
		while (exp_q.size() != 0) @(posedge hclk);
		ahb(1'h0, 12'h008, 32'h0000_0000);
		w = line_exp({cfg[12:10], 2'h0, cfg[7:0]}, 8'h41, 5'h03);
		chk(rd, {32'h0, w[15:0]});
		ahb(1'h0, 12'h014, 32'h0000_0000);
		chk(rd, {32'h0, e[47:32]});
		close_out();
	end
endmodule
